// File: mbag_pkg.sv
`default_nettype none
package mbag_pkg;
    // register bus geometry
    localparam int unsigned MBAG_AW = 8;
    localparam int unsigned MBAG_DW = 32;
    // register byte offsets, one aligned word each
    localparam logic [7:0] MBAG_OFS_MODE = 8'h00;
    localparam logic [7:0] MBAG_OFS_REV = 8'h04;
    localparam logic [7:0] MBAG_OFS_X_LO = 8'h08;
    localparam logic [7:0] MBAG_OFS_X_HI = 8'h0c;
    localparam logic [7:0] MBAG_OFS_Y_LO = 8'h10;
    localparam logic [7:0] MBAG_OFS_Y_HI = 8'h14;
    localparam logic [7:0] MBAG_OFS_STATUS = 8'h18;
    // field positions in address_mode_control and reverse_modifier_control
    localparam int unsigned MBAG_XSEL_LSB = 0;
    localparam int unsigned MBAG_YSEL_LSB = 4;
    localparam int unsigned MBAG_RSEL_LSB = 8;
    localparam int unsigned MBAG_YEN_BIT = 14;
    localparam int unsigned MBAG_XEN_BIT = 15;
    localparam int unsigned MBAG_REN_BIT = 15;
    localparam int unsigned MBAG_MOD_W = 15;
    // status word bits above the last effective address
    localparam int unsigned MBAG_STAT_REV_BIT = 16;
    localparam int unsigned MBAG_STAT_WRAP_BIT = 17;
    // pointer select value that switches a feature off
    localparam logic [3:0] MBAG_SEL_OFF = 4'hf;
    // reset values
    localparam logic [15:0] MBAG_MODE_RST = 16'h0fff;
    localparam logic [15:0] MBAG_REV_RST = 16'h0000;
    localparam logic [15:0] MBAG_BUF_RST = 16'h0000;
    // bus answers
    localparam logic [1:0] MBAG_RESP_OKAY = 2'b00;
    localparam logic [1:0] MBAG_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MBAG_MODE_IND = 2'b00,
        MBAG_MODE_POST = 2'b01,
        MBAG_MODE_PRE = 2'b10,
        MBAG_MODE_OFS = 2'b11
    } mbag_mode_e;

    typedef struct packed {
        logic valid;
        logic [3:0] ptr_id;
        logic [15:0] ptr;
        logic [15:0] offset;
        mbag_mode_e mode;
        logic is_write;
        logic is_byte;
        logic y_space;
    } mbag_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] ea;
        logic ptr_wr;
        logic [3:0] ptr_id;
        logic [15:0] new_ptr;
        logic rev_used;
        logic wrapped;
    } mbag_res_s;

    typedef struct packed {
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] mode_ctl;
        logic [15:0] rev_ctl;
        logic [15:0] x_lo;
        logic [15:0] x_hi;
        logic [15:0] y_lo;
        logic [15:0] y_hi;
        mbag_res_s res;
    } mbag_state_s;
endpackage : mbag_pkg
`default_nettype wire

// File: mbag_bitrev.sv
`timescale 1ns/1ps
`default_nettype none
module mbag_bitrev #(
    parameter int unsigned IDX_W = 15
) (
    input wire logic [IDX_W:0] ptr,
    input wire logic [IDX_W-1:0] modifier,
    output logic [IDX_W:0] next_ptr
);
    import mbag_pkg::*;

    // mirror a word index end for end
    function automatic logic [IDX_W-1:0] mbag_rev(input logic [IDX_W-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = 0; i < IDX_W; i++)
        begin
            r[i] = v[IDX_W-1-i];
        end
        return r;
    endfunction : mbag_rev

    logic [IDX_W-1:0] sum_rev;

    // carries run from msb toward lsb: add in mirrored order, mirror back
    // bits above the modifier's top bit never change, so an aligned base survives
    assign sum_rev = mbag_rev(ptr[IDX_W:1]) + mbag_rev(modifier);
    // word data only: the modifier counts words, the byte lsb stays clear
    assign next_ptr = {mbag_rev(sum_rev), 1'b0};
endmodule : mbag_bitrev
`default_nettype wire

// File: mbag_top.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mbag_top (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [mbag_pkg::MBAG_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [mbag_pkg::MBAG_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [mbag_pkg::MBAG_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [mbag_pkg::MBAG_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire mbag_pkg::mbag_req_s req,
    output mbag_pkg::mbag_res_s res
);
    import mbag_pkg::*;

    mbag_state_s st_ff;
    mbag_state_s nxt_st;

    // byte-lane merge for a 16-bit register under wstrb
    function automatic logic [15:0] mbag_merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : mbag_merge

    // word-align a bus address
    function automatic logic [7:0] mbag_word(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction : mbag_word

    // circular correction; unsigned compares so an overshoot still folds back
    function automatic logic [15:0] mbag_wrap(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] len;
        len = hi - lo + 16'h0001;
        if (a > hi)
        begin
            return a - len;
        end
        else if (a < lo)
        begin
            return a + len;
        end
        return a;
    endfunction : mbag_wrap

    logic [3:0] x_sel;
    logic [3:0] y_sel;
    logic [3:0] r_sel;
    logic x_circ;
    logic y_circ;
    logic rev_ok;
    logic circ_on;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] sum;
    logic [15:0] mod_addr;
    logic [15:0] rev_next;
    logic incr_mode;

    // field extraction from the control registers
    assign x_sel = st_ff.mode_ctl[MBAG_XSEL_LSB +: 4];
    assign y_sel = st_ff.mode_ctl[MBAG_YSEL_LSB +: 4];
    assign r_sel = st_ff.mode_ctl[MBAG_RSEL_LSB +: 4];

    // circular enables compare against any pointer number but 15, not a fixed subset
    assign x_circ = st_ff.mode_ctl[MBAG_XEN_BIT] && (x_sel != MBAG_SEL_OFF) && (req.ptr_id == x_sel);
    assign y_circ = st_ff.mode_ctl[MBAG_YEN_BIT] && (y_sel != MBAG_SEL_OFF) && (req.ptr_id == y_sel);

    // pre/post with a non-negative step counts as increment
    assign incr_mode = ((req.mode == MBAG_MODE_PRE) || (req.mode == MBAG_MODE_POST)) && !req.offset[15];

    // reversal only for x-space word writes through the chosen pointer
    assign rev_ok = st_ff.rev_ctl[MBAG_REN_BIT] && (r_sel != MBAG_SEL_OFF) && (req.ptr_id == r_sel)
                    && incr_mode && req.is_write && !req.is_byte && !req.y_space;

    // reversal wins on x writes; x reads keep circular correction
    assign circ_on = req.y_space ? y_circ : (x_circ && !rev_ok);
    assign lo = req.y_space ? st_ff.y_lo : st_ff.x_lo;
    assign hi = req.y_space ? st_ff.y_hi : st_ff.x_hi;
    assign sum = req.ptr + req.offset;
    assign mod_addr = circ_on ? mbag_wrap(sum, lo, hi) : sum;

    // reversed-carry adder: pointer and 15-bit modifier both passed in normal order
    mbag_bitrev #(
        .IDX_W(MBAG_MOD_W)
    ) u_bitrev (
        .ptr(req.ptr),
        .modifier(st_ff.rev_ctl[MBAG_MOD_W-1:0]),
        .next_ptr(rev_next)
    );

    // handshake outputs straight from the holding state
    assign s_axi_awready = !st_ff.aw_hold;
    assign s_axi_wready = !st_ff.w_hold;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign res = st_ff.res;

    // next-state: bus slave, register file and address unit
    always_comb
    begin
        nxt_st = st_ff;
        // address and data are caught independently, in either order
        if (s_axi_awvalid && !st_ff.aw_hold)
        begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_hold)
        begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_data = s_axi_wdata[15:0];
            nxt_st.w_strb = s_axi_wstrb[1:0];
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        // commit once both halves are held and the last answer is gone
        if (st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid)
        begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = MBAG_RESP_OKAY;
            unique case (mbag_word(st_ff.aw_addr))
                MBAG_OFS_MODE: nxt_st.mode_ctl = mbag_merge(st_ff.mode_ctl, st_ff.w_data, st_ff.w_strb);
                MBAG_OFS_REV: nxt_st.rev_ctl = mbag_merge(st_ff.rev_ctl, st_ff.w_data, st_ff.w_strb);
                MBAG_OFS_X_LO: nxt_st.x_lo = mbag_merge(st_ff.x_lo, st_ff.w_data, st_ff.w_strb);
                MBAG_OFS_X_HI: nxt_st.x_hi = mbag_merge(st_ff.x_hi, st_ff.w_data, st_ff.w_strb);
                MBAG_OFS_Y_LO: nxt_st.y_lo = mbag_merge(st_ff.y_lo, st_ff.w_data, st_ff.w_strb);
                MBAG_OFS_Y_HI: nxt_st.y_hi = mbag_merge(st_ff.y_hi, st_ff.w_data, st_ff.w_strb);
                MBAG_OFS_STATUS: nxt_st.bresp = MBAG_RESP_OKAY; // read-only, write dropped
                default: nxt_st.bresp = MBAG_RESP_SLVERR;
            endcase
        end
        // read answer registered on the same edge that takes the address
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_ff.rvalid)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = MBAG_RESP_OKAY;
            unique case (mbag_word(s_axi_araddr))
                MBAG_OFS_MODE: nxt_st.rdata = {16'h0000, st_ff.mode_ctl};
                MBAG_OFS_REV: nxt_st.rdata = {16'h0000, st_ff.rev_ctl};
                MBAG_OFS_X_LO: nxt_st.rdata = {16'h0000, st_ff.x_lo};
                MBAG_OFS_X_HI: nxt_st.rdata = {16'h0000, st_ff.x_hi};
                MBAG_OFS_Y_LO: nxt_st.rdata = {16'h0000, st_ff.y_lo};
                MBAG_OFS_Y_HI: nxt_st.rdata = {16'h0000, st_ff.y_hi};
                MBAG_OFS_STATUS: nxt_st.rdata = {14'h0000, st_ff.res.wrapped, st_ff.res.rev_used, st_ff.res.ea};
                default:
                begin
                    nxt_st.rdata = 32'h0000_0000;
                    nxt_st.rresp = MBAG_RESP_SLVERR;
                end
            endcase
        end
        // address unit: the last result stays visible through the status word
        nxt_st.res.valid = 1'b0;
        if (req.valid)
        begin
            nxt_st.res.valid = 1'b1;
            nxt_st.res.ptr_id = req.ptr_id;
            nxt_st.res.rev_used = 1'b0;
            nxt_st.res.wrapped = 1'b0;
            nxt_st.res.ptr_wr = 1'b0;
            nxt_st.res.new_ptr = req.ptr;
            nxt_st.res.ea = req.ptr;
            if (rev_ok)
            begin
                // the mode's own step is ignored; only the modifier is added
                nxt_st.res.rev_used = 1'b1;
                nxt_st.res.ptr_wr = 1'b1;
                nxt_st.res.new_ptr = rev_next;
                nxt_st.res.ea = (req.mode == MBAG_MODE_PRE) ? rev_next : {req.ptr[15:1], 1'b0};
            end
            else
            begin
                unique case (req.mode)
                    MBAG_MODE_IND: nxt_st.res.ea = req.ptr;
                    MBAG_MODE_POST:
                    begin
                        nxt_st.res.ptr_wr = 1'b1;
                        nxt_st.res.new_ptr = mod_addr;
                        nxt_st.res.wrapped = circ_on && (mod_addr != sum);
                    end
                    MBAG_MODE_PRE:
                    begin
                        nxt_st.res.ptr_wr = 1'b1;
                        nxt_st.res.new_ptr = mod_addr;
                        nxt_st.res.ea = mod_addr;
                        nxt_st.res.wrapped = circ_on && (mod_addr != sum);
                    end
                    MBAG_MODE_OFS:
                    begin
                        // corrected address used, pointer left alone
                        nxt_st.res.ea = mod_addr;
                        nxt_st.res.wrapped = circ_on && (mod_addr != sum);
                    end
                endcase
                // y space works on words, so its lsb is always clear
                if (req.y_space)
                begin
                    nxt_st.res.ea[0] = 1'b0;
                end
            end
        end
    end

    // selects reset to 15 so both features start switched off
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.mode_ctl <= MBAG_MODE_RST;
            st_ff.rev_ctl <= MBAG_REV_RST;
            st_ff.x_lo <= MBAG_BUF_RST;
            st_ff.x_hi <= MBAG_BUF_RST;
            st_ff.y_lo <= MBAG_BUF_RST;
            st_ff.y_hi <= MBAG_BUF_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    default clocking mbag_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // offset addressing never moves the pointer
    a_offset_no_wb: assert property (req.valid && req.mode == MBAG_MODE_OFS |=> !res.ptr_wr)
        else $error("offset mode wrote the pointer");
    // pre-modify writes back the address it used, except in y space, where only the address gets its lsb cleared
    a_pre_wb_ea: assert property (req.valid && req.mode == MBAG_MODE_PRE |=> res.ptr_wr && res.new_ptr == res.ea)
        else $error("pre-modify writeback differs from address");
    a_read_no_rev: assert property (req.valid && !req.is_write |=> !res.rev_used)
        else $error("read was bit reversed");
    a_rev_sel_off: assert property (req.valid && r_sel == MBAG_SEL_OFF |=> !res.rev_used)
        else $error("reversal with select 15");
    a_rev_lsb_zero: assert property (res.valid && res.rev_used |-> !res.ea[0] && !res.new_ptr[0])
        else $error("reversed address lsb set");
    a_byte_no_rev: assert property (req.valid && req.is_byte |=> !res.rev_used)
        else $error("byte access was bit reversed");
    a_rev_step_ignored: assert property (req.valid && rev_ok && req.ptr[4:0] == 5'h00
        && st_ff.rev_ctl[14:0] == 15'h0008 && req.offset != 16'h0000 |=> res.new_ptr[4:0] == 5'h10)
        else $error("reversal used the mode step");
    a_rev_no_wrap: assert property (res.valid && res.rev_used |-> !res.wrapped)
        else $error("circular correction on reversed write");
    a_rev_walk_step: assert property (req.valid && rev_ok && req.ptr[4:0] == 5'h10
        && st_ff.rev_ctl[14:0] == 15'h0008 |=> res.new_ptr[4:1] == 4'h4)
        else $error("walk index 8 not followed by 4");
    a_wrap_overshoot: assert property (req.valid && circ_on && req.mode == MBAG_MODE_PRE && req.ptr == hi
        && req.offset == 16'h0004 && (hi - lo) >= 16'h0004 |=> res.ea == $past(lo) + 16'h0003)
        else $error("overshoot not wrapped by buffer length");
    a_x_circ_off: assert property (req.valid && !req.y_space && !st_ff.mode_ctl[MBAG_XEN_BIT] |=> !res.wrapped)
        else $error("x wrap with enable clear");

    c_rev_write: cover property (res.valid && res.rev_used);
    c_x_wrap: cover property (res.valid && res.wrapped && res.ptr_wr);
    c_offset_wrap: cover property (req.valid && req.mode == MBAG_MODE_OFS && circ_on ##1 res.wrapped);
    c_read_circ_rev_on: cover property (req.valid && !req.is_write && x_circ && st_ff.rev_ctl[MBAG_REN_BIT]);
endmodule : mbag_top
`default_nettype wire

// File: mbag_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbag_cpu_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire mbag_pkg::mbag_req_s cmd,
    output mbag_pkg::mbag_req_s req,
    input wire mbag_pkg::mbag_res_s res
);
    import mbag_pkg::*;
    logic [15:0] regs [16];

    // preload off the rising edge, so a write-back landing on that edge cannot overwrite it
    task automatic load(input logic [3:0] id, input logic [15:0] v);
        @(negedge ref_clk);
        regs[id] = v;
    endtask : load

    // issue one access a cycle after the bench asks, pointer taken from the file;
    // idle fields toggle so a stale value is never mistaken for a live one
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req <= '0;
        end
        else
        begin
            req <= cmd.valid ? cmd : ~req;
            req.valid <= cmd.valid;
            req.ptr <= cmd.valid ? regs[cmd.ptr_id] : ~req.ptr;
            // the pipeline owns the write-back; the unit only proposes it
            if (res.valid && res.ptr_wr)
                regs[res.ptr_id] <= res.new_ptr;
        end
    end
endmodule : mbag_cpu_model
`default_nettype wire

// File: test_mbag_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_mbag_top;
    import mbag_pkg::*;
    logic ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    mbag_req_s cmd, req;
    mbag_res_s res;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [3:0] sels [4] = '{4'h0, 4'h7, 4'hd, 4'hf};

    mbag_top i_mbag_top (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .req(req), .res(res));
    mbag_cpu_model i_mbag_cpu_model (.ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd), .req(req), .res(res));

    // free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        begin
            $display("checks %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask : wrap_up

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        begin
            checked++;
            if (got !== exp)
            begin
                failures++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask : chk

    // write with both channels offered together, each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
        input logic [3:0] s = 4'hf);
        begin
            @(posedge ref_clk);
            awvalid <= 1'b1;
            awaddr <= a;
            wvalid <= 1'b1;
            wdata <= d;
            wstrb <= s;
            bready <= 1'b1;
            do
            begin
                @(posedge ref_clk);
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready)
                    wvalid <= 1'b0;
            end
            while (!bvalid);
            bready <= 1'b0;
            chk({38'h0, bresp}, {38'h0, er});
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        begin
            @(posedge ref_clk);
            arvalid <= 1'b1;
            araddr <= a;
            rready <= 1'b1;
            do
            begin
                @(posedge ref_clk);
                if (arvalid && arready)
                    arvalid <= 1'b0;
            end
            while (!rvalid);
            rready <= 1'b0;
            chk({6'h0, rresp, rdata}, {6'h0, er, ed});
        end
    endtask : axi_rd

    // one access; f holds {reversed, wrapped, write-back}
    task automatic acc(input logic [3:0] id, input mbag_mode_e m, input logic [15:0] o, input logic [2:0] f,
        input logic [15:0] ea, input logic [15:0] np, input logic wr = 1'b1, input logic by = 1'b0,
        input logic ys = 1'b0);
        begin
            @(posedge ref_clk);
            cmd <= '{1'b1, id, 16'h0, o, m, wr, by, ys};
            @(posedge ref_clk);
            cmd.valid <= 1'b0;
            do
            begin
                @(posedge ref_clk);
            end
            while (!res.valid);
            chk({5'h0, res.rev_used, res.wrapped, res.ptr_wr, res.ea, f[0] ? res.new_ptr : 16'h0},
                {5'h0, f, ea, f[0] ? np : 16'h0});
        end
    endtask : acc

    function automatic logic [3:0] rv4(input int i);
        logic [3:0] v;
        v = i[3:0];
        return {v[0], v[1], v[2], v[3]};
    endfunction : rv4

    // a hung handshake must not stall the run
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        cmd = '0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        // reset values, refusals and byte lanes
        axi_rd(MBAG_OFS_MODE, 32'h0000_0fff, MBAG_RESP_OKAY);
        axi_rd(MBAG_OFS_REV, 32'h0, MBAG_RESP_OKAY);
        axi_rd(8'h1c, 32'h0, MBAG_RESP_SLVERR);
        axi_wr(8'h20, 32'h1234, MBAG_RESP_SLVERR);
        axi_wr(MBAG_OFS_STATUS, 32'hffff, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_X_LO, 32'habcd_1000, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_X_HI, 32'h0000_ee1f, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_X_HI, 32'h0000_10aa, MBAG_RESP_OKAY, 4'h2);
        axi_rd(MBAG_OFS_X_LO, 32'h0000_1000, MBAG_RESP_OKAY);
        axi_rd(MBAG_OFS_X_HI, 32'h0000_101f, MBAG_RESP_OKAY);
        $display("test registers done");
        // circular buffer 0x1000..0x101f on several selected pointers
        for (int k = 0; k < 4; k++)
        begin
            axi_wr(MBAG_OFS_MODE, {16'h0, 12'h8ff, sels[k]}, MBAG_RESP_OKAY);
            i_mbag_cpu_model.load(sels[k], 16'h101e);
            acc(sels[k], MBAG_MODE_POST, 16'h0002, sels[k] == 4'hf ? 3'b001 : 3'b011, 16'h101e,
                sels[k] == 4'hf ? 16'h1020 : 16'h1000);
        end
        axi_wr(MBAG_OFS_MODE, 32'h0000_8ff2, MBAG_RESP_OKAY);
        i_mbag_cpu_model.load(4'h2, 16'h101e);
        acc(4'h2, MBAG_MODE_POST, 16'h0004, 3'b011, 16'h101e, 16'h1002);
        acc(4'h2, MBAG_MODE_PRE, 16'hfffc, 3'b011, 16'h101e, 16'h101e);
        acc(4'h2, MBAG_MODE_OFS, 16'h0020, 3'b010, 16'h101e, 16'h0);
        acc(4'h2, MBAG_MODE_POST, 16'h0002, 3'b011, 16'h101e, 16'h1000);
        i_mbag_cpu_model.load(4'h3, 16'h101e);
        acc(4'h3, MBAG_MODE_POST, 16'h0004, 3'b001, 16'h101e, 16'h1022);
        axi_rd(MBAG_OFS_STATUS, 32'h0000_101e, MBAG_RESP_OKAY);
        i_mbag_cpu_model.load(4'h2, 16'h101f);
        acc(4'h2, MBAG_MODE_PRE, 16'h0004, 3'b011, 16'h1003, 16'h1003);
        $display("test circular done");
        // reversed walk over a 16-word buffer at 0x200, circular range 0x200..0x20f also on
        axi_wr(MBAG_OFS_X_LO, 32'h0000_0200, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_X_HI, 32'h0000_020f, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_MODE, 32'h0000_84f4, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_REV, 32'h0000_8008, MBAG_RESP_OKAY); // half of a 16-word buffer
        i_mbag_cpu_model.load(4'h4, 16'h0200); // start has its low 5 bits clear
        for (int i = 0; i < 16; i++)
            acc(4'h4, MBAG_MODE_POST, 16'h0006, 3'b101, {11'h010, rv4(i), 1'b0},
                {11'h010, rv4(i + 1), 1'b0});
        i_mbag_cpu_model.load(4'h4, 16'h0203);
        acc(4'h4, MBAG_MODE_PRE, 16'h0002, 3'b101, 16'h0212, 16'h0212);
        acc(4'h4, MBAG_MODE_POST, 16'h0002, 3'b011, 16'h0212, 16'h0204, 1'b0);
        acc(4'h4, MBAG_MODE_POST, 16'h0001, 3'b001, 16'h0204, 16'h0205, 1'b1, 1'b1);
        acc(4'h4, MBAG_MODE_POST, 16'hffff, 3'b001, 16'h0205, 16'h0204);
        acc(4'h4, MBAG_MODE_OFS, 16'h0002, 3'b000, 16'h0206, 16'h0);
        // reversal off, and a post-modify access follows the modifier write at once
        axi_wr(MBAG_OFS_REV, 32'h0000_0008, MBAG_RESP_OKAY);
        acc(4'h4, MBAG_MODE_POST, 16'h0002, 3'b001, 16'h0204, 16'h0206);
        $display("test reversed done");
        // y-space buffer 0x800..0x807: word addresses, plain indirect too
        axi_wr(MBAG_OFS_Y_LO, 32'h0000_0800, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_Y_HI, 32'h0000_0807, MBAG_RESP_OKAY);
        axi_wr(MBAG_OFS_MODE, 32'h0000_4f5f, MBAG_RESP_OKAY);
        i_mbag_cpu_model.load(4'h5, 16'h0806);
        acc(4'h5, MBAG_MODE_POST, 16'h0002, 3'b011, 16'h0806, 16'h0800, 1'b1, 1'b0, 1'b1);
        acc(4'h5, MBAG_MODE_IND, 16'h0002, 3'b000, 16'h0800, 16'h0, 1'b1, 1'b0, 1'b1);
        i_mbag_cpu_model.load(4'h5, 16'h0803);
        acc(4'h5, MBAG_MODE_OFS, 16'h0000, 3'b000, 16'h0802, 16'h0, 1'b1, 1'b0, 1'b1);
        $display("test y space done");
        wrap_up();
    end
endmodule : test_mbag_top
`default_nettype wire
